// File: dv/esb_ext_dev.sv
/* External memory and external bus master model.
   Assumes the bench resolves shared pins from all enables. */
`timescale 1ns/1ps
module esb_ext_dev
(
  // Resolved pins
  input  wire         core_clk,
  input  wire  [21:0] addr,
  input  wire  [1:0]  lane_n,
  input  wire         wr_n,
  input  wire         rd_n,
  input  wire  [15:0] data,
  // Model drive
  output logic [15:0] drv_data,
  output logic [1:0]  drv_en,
  output logic [21:0] m_addr = 22'h0,
  output logic        m_wr_n = 1'b1
);
  logic [15:0] mem [0:15];
  logic [15:0] m_dat = 16'h0;
  logic        wr_q = 1'b1;
  // Lane bit0 is the high byte; drivers stay off while the read strobe is high, except during a master write, which drives both lanes
  assign drv_en = m_wr_n ? {~rd_n & ~lane_n[0], ~rd_n & ~lane_n[1]} : 2'h3;
  assign drv_data = m_wr_n ? mem[addr[3:0]] : m_dat;
  // Data are taken at the strobe fall, as the bus may float to the pull-ups before it rises
  always @(posedge core_clk)
  begin
    wr_q <= wr_n;
    if (wr_q && !wr_n && m_wr_n && !lane_n[1])
      mem[addr[3:0]][7:0] <= data[7:0];
    if (wr_q && !wr_n && m_wr_n && !lane_n[0])
      mem[addr[3:0]][15:8] <= data[15:8];
  end
  // Call only while the bus is granted away
  task master_write(input logic [21:0] a, input logic [15:0] d);
    m_addr <= a;
    m_dat <= d;
    repeat (2) @(posedge core_clk);
    m_wr_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    m_wr_n <= 1'b1;
    @(posedge core_clk);
    m_addr <= ~a;
  endtask
endmodule // esb_ext_dev

// File: dv/esb_port_assertions.sv
/* Assertions on the pins and APB answer of esb_port.
   Assumes binding to esb_port; sees only its ports. */
`timescale 1ns/1ps
module esb_port_chk
(
  // Clock, reset and inputs
  input wire       core_clk, sys_rst, psel, penable, highz_n, bus_grant_in_n, narrow_bus_strap_n_in,
  input wire       int_irq_normal, int_irq_fast,
  // Watched outputs
  input wire       pready, addr_oe, byte_lane_enable_n_oe, write_strobe_n_out, write_strobe_n_oe,
  input wire       read_strobe_n_out, read_strobe_n_oe, data_lo_oe, data_hi_oe, data_pullup_en,
  input wire       transfer_ack_n, abort_n, irq_out, external_bus_clock_out,
  input wire [1:0] byte_lane_enable_n_out,
  input wire [3:0] device_select
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Reset checks cannot be disabled by the reset they watch
  AST_RST_DATA: assert property (disable iff (1'b0) sys_rst |=> !data_lo_oe && !data_hi_oe && data_pullup_en)
    else $error("data drive in reset");
  AST_RST_SEL: assert property (disable iff (1'b0) sys_rst |=> device_select == 4'h7)
    else $error("select reset level");
  AST_GRANT: assert property (!bus_grant_in_n [*4] |-> !(addr_oe | byte_lane_enable_n_oe | write_strobe_n_oe
    | read_strobe_n_oe | data_lo_oe)) else $error("drive while granted away");
  AST_HIGHZ: assert property (!highz_n [*4] |-> !(addr_oe | data_lo_oe | data_hi_oe | write_strobe_n_oe
    | read_strobe_n_oe | byte_lane_enable_n_oe)) else $error("drive in highz");
  AST_NARROW: assert property (!narrow_bus_strap_n_in [*4] |-> !byte_lane_enable_n_oe
    || byte_lane_enable_n_out == 2'h1) else $error("narrow lanes");
  AST_RD_DATA: assert property (!read_strobe_n_out && read_strobe_n_oe |-> !data_lo_oe)
    else $error("drive during read");
  AST_ACK_END: assert property ($fell(transfer_ack_n) && !write_strobe_n_out |-> ##[3:6] write_strobe_n_out)
    else $error("cycle not ended");
  AST_ABORT: assert property ($fell(abort_n) |-> !abort_n [*4] ##1 abort_n)
    else $error("abort width");
  AST_IRQ: assert property ($rose(int_irq_fast) || $rose(int_irq_normal) |=> irq_out)
    else $error("irq late");
  AST_EXTERNAL_BUS_CLOCK_OUT: assert property ($rose(external_bus_clock_out) |-> external_bus_clock_out [*2]
    ##1 !external_bus_clock_out [*2] ##1 external_bus_clock_out) else $error("bus clock");
  AST_APB_RDY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing");
endmodule // esb_port_chk

bind esb_port esb_port_chk chk_u (.core_clk, .sys_rst, .psel, .penable, .highz_n, .bus_grant_in_n,
  .narrow_bus_strap_n_in, .int_irq_normal, .int_irq_fast, .pready, .addr_oe, .byte_lane_enable_n_oe,
  .write_strobe_n_out, .write_strobe_n_oe, .read_strobe_n_out, .read_strobe_n_oe, .data_lo_oe, .data_hi_oe,
  .data_pullup_en, .transfer_ack_n, .abort_n, .irq_out, .external_bus_clock_out, .byte_lane_enable_n_out,
  .device_select);

// File: dv/testbench.sv
/* Self-checking bench for esb_port with an external device model.
   Assumes a 200 MHz core clock; pins are resolved here. */
`timescale 1ns/1ps
module testbench;
  logic        core_clk, sys_rst, psel, penable, pwrite, int_irq_normal, int_irq_fast, int_txn_done, e_q;
  logic        bus_grant_in_n, ext_boot_n, highz_n, ext_strap_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  wire  [31:0] prdata;
  wire         pready, pslverr, esb_int, addr_oe, byte_lane_enable_n_oe, write_strobe_n_out, write_strobe_n_oe;
  wire         read_strobe_n_out, read_strobe_n_oe, data_lo_oe, data_hi_oe, data_pullup_en, narrow_bus_strap_n_out;
  wire         narrow_bus_strap_n_oe, transfer_ack_n, abort_n, boot_map_ext, irq_out, external_bus_clock_out, p_wr_n;
  wire  [21:0] addr_out, p_addr;
  wire  [1:0]  byte_lane_enable_n_out, p_en;
  wire  [3:0]  device_select;
  wire  [15:0] data_out, p_data;
  int          err_total, n_checks;
  // Each pin takes its level from whoever enables it; idle data sits on the pull-ups
  wire [21:0] addr_in = addr_oe ? addr_out : p_addr;
  wire [1:0]  byte_lane_enable_n_in = byte_lane_enable_n_oe ? byte_lane_enable_n_out : {2{p_wr_n}};
  wire        write_strobe_n_in = write_strobe_n_oe ? write_strobe_n_out : p_wr_n;
  wire        read_strobe_n_in = read_strobe_n_oe ? read_strobe_n_out : 1'b1;
  wire [15:0] data_in = {data_hi_oe ? data_out[15:8] : p_en[1] ? p_data[15:8] : 8'hFF,
                         data_lo_oe ? data_out[7:0] : p_en[0] ? p_data[7:0] : 8'hFF};
  wire        narrow_bus_strap_n_in = ext_strap_n & ~(narrow_bus_strap_n_oe & ~narrow_bus_strap_n_out);
  esb_port dut_u (.core_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .esb_int, .int_irq_normal, .int_irq_fast, .int_txn_done, .addr_in, .addr_out, .addr_oe,
    .byte_lane_enable_n_in, .byte_lane_enable_n_out, .byte_lane_enable_n_oe, .write_strobe_n_in,
    .write_strobe_n_out, .write_strobe_n_oe, .read_strobe_n_in, .read_strobe_n_out, .read_strobe_n_oe,
    .data_in, .data_out, .data_lo_oe, .data_hi_oe, .data_pullup_en, .bus_grant_in_n, .narrow_bus_strap_n_in,
    .narrow_bus_strap_n_out, .narrow_bus_strap_n_oe, .ext_boot_n, .highz_n, .transfer_ack_n, .abort_n,
    .device_select, .boot_map_ext, .irq_out, .external_bus_clock_out);
  esb_ext_dev part_u (.core_clk, .addr(addr_in), .lane_n(byte_lane_enable_n_in), .wr_n(write_strobe_n_in),
    .rd_n(read_strobe_n_in), .data(data_in), .drv_data(p_data), .drv_en(p_en), .m_addr(p_addr), .m_wr_n(p_wr_n));
  task chk(input logic [32:0] g, input logic [32:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk(n < 20, 32'h1, "apb hang");
    q = prdata;
    e_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task wait_low(input int k);
    int n;
    n = 0;
    while ((k ? abort_n : transfer_ack_n) !== 1'b0 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 300, 32'h1, "no low pulse");
  endtask
  task t_reset;
    repeat (6) @(posedge core_clk);
    chk(device_select, 32'h7, "sel idle");
    chk(boot_map_ext, 32'h1, "boot map");
    rd(8'h00);
    chk(q, 32'h24, "ctrl reset");
    rd(8'h10);
    chk(q & 32'h4, 32'h4, "boot state");
    rd(8'h2C);
    chk({e_q, q}, 33'h100000000, "unmapped");
  endtask
  task t_write;
    wr(8'h24, 32'h1);
    wr(8'h04, 32'h3FFFFF);
    wr(8'h08, 32'hBEEF);
    wr(8'h0C, 32'h3);
    wait_low(0);
    chk(addr_out, 32'h3FFFFF, "addr");
    chk(device_select, 32'h6, "sel0 low");
    chk({write_strobe_n_out, data_lo_oe, data_hi_oe, data_out}, 32'h3BEEF, "write pins");
    repeat (8) @(posedge core_clk);
    chk({esb_int, part_u.mem[15]}, 32'h1BEEF, "stored");
    rd(8'h20);
    chk(q, 32'h1, "done");
    rd(8'h20);
    chk({esb_int, q}, 33'h0, "cleared");
  endtask
  task t_read;
    part_u.mem[5] = 16'h1234;
    wr(8'h24, 32'h0);
    wr(8'h00, 32'h2C);
    wr(8'h04, 32'h5);
    repeat (2) @(posedge core_clk);
    chk(device_select, 32'h5, "pol idle");
    wr(8'h0C, 32'h15);
    wait_low(0);
    chk({read_strobe_n_out, device_select, byte_lane_enable_n_out}, 32'h1D, "read pins");
    repeat (8) @(posedge core_clk);
    chk(esb_int, 32'h0, "masked");
    rd(8'h14);
    chk(q & 32'hFF, 32'h34, "rdata");
    rd(8'h20);
    chk(q, 32'h1, "read done");
  endtask
  task t_abort;
    wr(8'h00, 32'hF24);
    wr(8'h0C, 32'h3);
    // Let the sequencer leave idle first, else the abort is ignored
    repeat (4) @(posedge core_clk);
    wr(8'h0C, 32'h103);
    wait_low(1);
    repeat (6) @(posedge core_clk);
    rd(8'h20);
    chk(q & 32'h3, 32'h2, "abort");
  endtask
  task t_narrow;
    wr(8'h00, 32'h25);
    wr(8'h18, 32'h80A5);
    repeat (4) @(posedge core_clk);
    chk({narrow_bus_strap_n_oe, narrow_bus_strap_n_out, byte_lane_enable_n_out}, 32'h9, "strap");
    chk({data_hi_oe, data_out[15:8]}, 32'h1A5, "gpio out");
    rd(8'h1C);
    chk(q, 32'hA5, "gpio in");
    wr(8'h00, 32'h24);
    ext_strap_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(8'h10);
    chk(q & 32'h2, 32'h2, "ext strap");
    ext_strap_n <= 1'b1;
  endtask
  task t_pins;
    chk(addr_oe, 32'h1, "driven");
    highz_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk({addr_oe, read_strobe_n_oe, byte_lane_enable_n_oe}, 32'h0, "highz");
    highz_n <= 1'b1;
    bus_grant_in_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk({addr_oe, write_strobe_n_oe, data_lo_oe}, 32'h0, "granted");
    part_u.master_write(22'h12, 16'hC0DE);
    rd(8'h28);
    chk(q, 32'hC0DE, "extcap");
    bus_grant_in_n <= 1'b1;
  endtask
  task t_events;
    wr(8'h00, 32'h26);
    int_txn_done <= 1'b1;
    @(posedge core_clk);
    int_txn_done <= 1'b0;
    wait_low(0);
    int_irq_fast <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(irq_out, 32'h1, "fast irq");
    {int_irq_fast, int_irq_normal} <= 2'h1;
    repeat (3) @(posedge core_clk);
    chk(irq_out, 32'h1, "normal irq");
  endtask
  task stop_test;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
  initial
  begin
    {sys_rst, bus_grant_in_n, highz_n, ext_strap_n} = 4'hF;
    {psel, penable, pwrite, int_irq_normal, int_irq_fast, int_txn_done, ext_boot_n} = 7'h0;
    {paddr, pwdata} = 40'h0;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge core_clk);
    chk({data_lo_oe, data_hi_oe, data_pullup_en}, 32'h1, "reset pins");
    sys_rst <= 1'b0;
    t_reset();
    t_write();
    t_read();
    t_abort();
    t_narrow();
    t_pins();
    t_events();
    stop_test();
  end
endmodule // testbench

// File: hw/esb_consts.vh
/*
  Constants of the external system bus port: APB register offsets, field
  positions, reset values and bus clock timing.
  Assumes a 200 MHz core clock and an APB master with 32-bit data.
*/
`ifndef ESB_CONSTS_VH
`define ESB_CONSTS_VH

`define ESB_OFS_CTRL        8'h00
`define ESB_OFS_ADDR        8'h04
`define ESB_OFS_WDATA       8'h08
`define ESB_OFS_CMD         8'h0C
`define ESB_OFS_STATE       8'h10
`define ESB_OFS_RDATA       8'h14
`define ESB_OFS_GPIO        8'h18
`define ESB_OFS_GPIO_IN     8'h1C
`define ESB_OFS_STATUS      8'h20
`define ESB_OFS_MASK        8'h24
`define ESB_OFS_EXTCAP      8'h28

`define ESB_CTRL_NARROW     0
`define ESB_CTRL_TRACE      1
`define ESB_CTRL_PULLUP     2
`define ESB_CTRL_POL_LO     3
`define ESB_CTRL_POL_HI     5
`define ESB_CTRL_WAIT_LO    8
`define ESB_CTRL_WAIT_HI    11
`define ESB_CTRL_RESET      12'h024

`define ESB_CMD_START       0
`define ESB_CMD_WRITE       1
`define ESB_CMD_SEL_LO      2
`define ESB_CMD_SEL_HI      3
`define ESB_CMD_LANE_LO     4
`define ESB_CMD_LANE_HI     5
`define ESB_CMD_ABORT       8

`define ESB_EV_DONE         0
`define ESB_EV_ABORT        1
`define ESB_EV_EXTWR        2
`define ESB_EV_W            3

`define ESB_CLK_NS          5
`define ESB_EXTERNAL_BUS_CLOCK_OUT_NS       20
`define ESB_PHASES          (`ESB_EXTERNAL_BUS_CLOCK_OUT_NS / `ESB_CLK_NS)
`define ESB_PHASE_LAST      2'h3
`define ESB_PHASE_HIGH      2'h2

`endif

// File: hw/esb_port.v
/*
  External system bus port: APB register slave, external transfer
  sequencer, pin output enables, strap capture and interrupt logic.
  Assumes pins are resolved by the surroundings from out/oe pairs and that
  internal interrupt and transaction inputs are on core_clk.
*/
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "esb_consts.vh"

module esb_port
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // APB slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         esb_int,
  // Internal sources
  input  wire        int_irq_normal,
  input  wire        int_irq_fast,
  input  wire        int_txn_done,
  // Address, lanes and strobes
  input  wire [21:0] addr_in,
  output reg  [21:0] addr_out,
  output reg         addr_oe,
  input  wire [1:0]  byte_lane_enable_n_in,
  output reg  [1:0]  byte_lane_enable_n_out,
  output reg         byte_lane_enable_n_oe,
  input  wire        write_strobe_n_in,
  output reg         write_strobe_n_out,
  output reg         write_strobe_n_oe,
  input  wire        read_strobe_n_in,
  output reg         read_strobe_n_out,
  output reg         read_strobe_n_oe,
  // Data
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_lo_oe,
  output reg         data_hi_oe,
  output reg         data_pullup_en,
  // Control pins
  input  wire        bus_grant_in_n,
  input  wire        narrow_bus_strap_n_in,
  output reg         narrow_bus_strap_n_out,
  output reg         narrow_bus_strap_n_oe,
  input  wire        ext_boot_n,
  input  wire        highz_n,
  output reg         transfer_ack_n,
  output reg         abort_n,
  output reg  [3:0]  device_select,
  output reg         boot_map_ext,
  output reg         irq_out,
  output reg         external_bus_clock_out
);

  localparam S_IDLE = 4'b0001;
  localparam S_ADDR = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_ACK  = 4'b1000;
  localparam SW     = 46;
  // Bit positions of the pins in the synchroniser word
  localparam SB_WR    = 24;
  localparam SB_GRANT = 26;
  localparam SB_STRAP = 27;
  localparam SB_BOOT  = 28;
  localparam SB_HIGHZ = 29;
  localparam SB_DATA  = 30;

  // Select level for line i: asserted or not, per polarity
  function sel_level;
    input active;
    input pol_high;
    begin
      sel_level = active ? pol_high : ~pol_high;
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Two-flop synchroniser for every pin input
  reg  [SW-1:0] sync_a;
  reg  [SW-1:0] sync_b;
  wire [SW-1:0] raw_in = {data_in, highz_n, ext_boot_n, narrow_bus_strap_n_in,
                          bus_grant_in_n, read_strobe_n_in, write_strobe_n_in,
                          byte_lane_enable_n_in, addr_in};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk)
      begin
        sync_a[gi] <= raw_in[gi];
        sync_b[gi] <= sync_a[gi];
      end
    end
  endgenerate

  // A data word reaches rdata only after a strobe has qualified it for cycles,
  // but extcap takes it at the synchronised strobe fall and the GPIO input register at any time
  wire [15:0] s_data  = sync_b[SB_DATA+15:SB_DATA];
  wire        s_highz = ~sync_b[SB_HIGHZ];
  wire        s_boot  = sync_b[SB_BOOT];
  wire        s_strap = sync_b[SB_STRAP];
  wire        s_grant = sync_b[SB_GRANT];
  wire        s_wr_n  = sync_b[SB_WR];

  // Registers
  reg  [11:0] ctrl;
  reg  [21:0] xaddr;
  reg  [15:0] wdata;
  reg  [15:0] rdata;
  reg  [15:0] gpio;
  reg  [15:0] extcap;
  reg  [`ESB_EV_W-1:0] status;
  reg  [`ESB_EV_W-1:0] mask;
  reg         start_pend;
  reg         abort_pend;
  reg         mon_pend;
  reg         cmd_wr;
  reg  [1:0]  cmd_sel;
  reg  [1:0]  cmd_lane_n;
  reg  [3:0]  state;
  reg  [3:0]  wcnt;
  reg  [1:0]  phase;
  reg         boot_done;
  reg         wr_seen;

  wire narrow  = ctrl[`ESB_CTRL_NARROW] | ~s_strap;
  wire owner   = s_grant;
  wire tick    = (phase == `ESB_PHASE_LAST);
  wire busy    = ~state[0];
  wire apb_set = psel & ~penable;
  wire apb_acc = psel & penable & pready;
  wire apb_wr  = apb_acc & pwrite;
  wire apb_rd  = apb_acc & ~pwrite;
  wire [2:0] pol = ctrl[`ESB_CTRL_POL_HI:`ESB_CTRL_POL_LO];

  wire cmd_hit = apb_wr & hit(paddr, `ESB_OFS_CMD);
  wire ext_wr_edge = ~owner & ~s_wr_n & ~wr_seen;

  reg  [`ESB_EV_W-1:0] ev;
  reg  [3:0]           next_state;
  reg                  do_abort;

  always @*
  begin
    next_state = state;
    do_abort   = 1'b0;
    ev         = {`ESB_EV_W{1'b0}};
    ev[`ESB_EV_EXTWR] = ext_wr_edge;
    if (tick)
    begin
      // Losing the bus mid-cycle ends the transfer as an abort
      if (busy && (abort_pend || !owner))
        do_abort = 1'b1;
      case (state)
        S_IDLE:
          if (start_pend && owner && !mon_pend)
            next_state = S_ADDR;
        S_ADDR:
          next_state = S_WAIT;
        S_WAIT:
          if (wcnt == 4'h0)
            next_state = S_ACK;
        S_ACK:
          next_state = S_IDLE;
        default:
          next_state = S_IDLE;
      endcase
      if (do_abort)
        next_state = S_IDLE;
      ev[`ESB_EV_ABORT] = do_abort;
      ev[`ESB_EV_DONE]  = state[3] & ~do_abort;
    end
  end

  // Register file and sequencer
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl       <= `ESB_CTRL_RESET;
      xaddr      <= 22'h000000;
      wdata      <= 16'h0000;
      rdata      <= 16'h0000;
      gpio       <= 16'h0000;
      extcap     <= 16'h0000;
      status     <= {`ESB_EV_W{1'b0}};
      mask       <= {`ESB_EV_W{1'b0}};
      start_pend <= 1'b0;
      abort_pend <= 1'b0;
      mon_pend   <= 1'b0;
      cmd_wr     <= 1'b0;
      cmd_sel    <= 2'h0;
      cmd_lane_n <= 2'h0;
      state      <= S_IDLE;
      wcnt       <= 4'h0;
      phase      <= 2'h0;
      boot_done  <= 1'b0;
      boot_map_ext <= 1'b0;
      wr_seen    <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      state <= next_state;
      // Idles low like the released strobe, so reset makes no false edge
      wr_seen <= ~owner & ~s_wr_n;
      // Boot strap is taken once, after the synchroniser has filled
      if (!boot_done && phase == `ESB_PHASE_LAST)
      begin
        boot_done    <= 1'b1;
        boot_map_ext <= ~s_boot;
      end
      if (ext_wr_edge)
        extcap <= s_data;
      if (apb_wr)
      begin
        if (hit(paddr, `ESB_OFS_CTRL))
          ctrl <= pwdata[11:0];
        if (hit(paddr, `ESB_OFS_ADDR))
          xaddr <= pwdata[21:0];
        if (hit(paddr, `ESB_OFS_WDATA))
          wdata <= pwdata[15:0];
        if (hit(paddr, `ESB_OFS_GPIO))
          gpio <= pwdata[15:0];
        if (hit(paddr, `ESB_OFS_MASK))
          mask <= pwdata[`ESB_EV_W-1:0];
      end
      // A start while busy is ignored
      if (cmd_hit && pwdata[`ESB_CMD_START] && !busy && !start_pend)
      begin
        start_pend <= 1'b1;
        cmd_wr     <= pwdata[`ESB_CMD_WRITE];
        cmd_sel    <= pwdata[`ESB_CMD_SEL_HI:`ESB_CMD_SEL_LO];
        cmd_lane_n <= pwdata[`ESB_CMD_LANE_HI:`ESB_CMD_LANE_LO];
      end
      else if (tick && state[0] && owner && !mon_pend)
        start_pend <= 1'b0;
      if (cmd_hit && pwdata[`ESB_CMD_ABORT] && busy)
        abort_pend <= 1'b1;
      else if (tick)
        abort_pend <= 1'b0;
      if (int_txn_done && ctrl[`ESB_CTRL_TRACE])
        mon_pend <= 1'b1;
      else if (tick && state[0])
        mon_pend <= 1'b0;
      if (tick && state[1])
        wcnt <= ctrl[`ESB_CTRL_WAIT_HI:`ESB_CTRL_WAIT_LO];
      else if (tick && state[2] && wcnt != 4'h0)
        wcnt <= wcnt - 4'h1;
      if (tick && state[3] && !cmd_wr)
        rdata <= narrow ? {8'h00, s_data[7:0]} : s_data;
      // Only the bits that the read returned are cleared, so an event that
      // lands between setup and access waits for the next read
      if (apb_rd && hit(paddr, `ESB_OFS_STATUS))
        status <= (status & ~prdata[`ESB_EV_W-1:0]) | ev;
      else
        status <= status | ev;
    end
  end

  // APB answer: ready in the access phase, no wait states
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      esb_int <= 1'b0;
    end
    else
    begin
      esb_int <= |(status & mask);
      pready  <= apb_set;
      pslverr <= apb_set & (paddr[1:0] != 2'h0 || paddr > `ESB_OFS_EXTCAP);
      if (apb_set)
      begin
        case (paddr)
          `ESB_OFS_CTRL:    prdata <= {20'h00000, ctrl};
          `ESB_OFS_ADDR:    prdata <= {10'h000, xaddr};
          `ESB_OFS_WDATA:   prdata <= {16'h0000, wdata};
          `ESB_OFS_CMD:     prdata <= {26'h0000000, cmd_lane_n, cmd_sel, cmd_wr, start_pend};
          `ESB_OFS_STATE:   prdata <= {28'h0000000, owner, boot_map_ext, narrow, busy};
          `ESB_OFS_RDATA:   prdata <= {16'h0000, rdata};
          `ESB_OFS_GPIO:    prdata <= {16'h0000, gpio};
          `ESB_OFS_GPIO_IN: prdata <= {24'h000000, s_data[15:8]};
          `ESB_OFS_STATUS:  prdata <= {29'h00000000, status};
          `ESB_OFS_MASK:    prdata <= {29'h00000000, mask};
          `ESB_OFS_EXTCAP:  prdata <= {16'h0000, extcap};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Pins, all from flops; high-impedance command overrides every enable except narrow_bus_strap_n_oe and data_pullup_en
  wire cyc    = busy & owner;
  wire drv_wr = cyc & cmd_wr & ~state[1];
  wire drive  = owner & ~s_highz;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      addr_out               <= 22'h000000;
      addr_oe                <= 1'b0;
      byte_lane_enable_n_out <= 2'h3;
      byte_lane_enable_n_oe  <= 1'b0;
      write_strobe_n_out     <= 1'b1;
      write_strobe_n_oe      <= 1'b0;
      read_strobe_n_out      <= 1'b1;
      read_strobe_n_oe       <= 1'b0;
      data_out               <= 16'h0000;
      data_lo_oe             <= 1'b0;
      data_hi_oe             <= 1'b0;
      data_pullup_en         <= 1'b1;
      narrow_bus_strap_n_out <= 1'b0;
      narrow_bus_strap_n_oe  <= 1'b0;
      transfer_ack_n         <= 1'b1;
      abort_n                <= 1'b1;
      device_select          <= 4'b0111;
      irq_out                <= 1'b0;
      external_bus_clock_out <= 1'b0;
    end
    else
    begin
      external_bus_clock_out <= (phase >= `ESB_PHASE_HIGH);
      addr_out   <= xaddr;
      addr_oe    <= drive;
      byte_lane_enable_n_oe <= drive;
      write_strobe_n_oe     <= drive;
      read_strobe_n_oe      <= drive;
      if (narrow)
        byte_lane_enable_n_out <= 2'b01;
      else
        byte_lane_enable_n_out <= cyc ? cmd_lane_n : 2'b11;
      write_strobe_n_out <= ~drv_wr;
      read_strobe_n_out  <= ~(cyc & ~cmd_wr & ~state[1]);
      data_out[7:0]  <= wdata[7:0];
      data_out[15:8] <= narrow ? gpio[7:0] : wdata[15:8];
      data_lo_oe <= drv_wr & ~s_highz;
      data_hi_oe <= ~s_highz & (narrow ? gpio[15] : drv_wr & ~cmd_lane_n[0]);
      data_pullup_en <= ctrl[`ESB_CTRL_PULLUP];
      narrow_bus_strap_n_oe <= ctrl[`ESB_CTRL_NARROW];
      transfer_ack_n <= ~((state[3] & cyc) | (mon_pend & state[0]));
      // Held for a whole bus clock period so the far side sees it
      if (tick)
        abort_n <= ~do_abort;
      device_select[0] <= ~(cyc && cmd_sel == 2'h0);
      device_select[1] <= sel_level(cyc && cmd_sel == 2'h1, pol[0]);
      device_select[2] <= sel_level(cyc && cmd_sel == 2'h2, pol[1]);
      device_select[3] <= sel_level(cyc && cmd_sel == 2'h3, pol[2]);
      irq_out <= int_irq_normal | int_irq_fast;
    end
  end

endmodule // esb_port
